// File: inc/out_sel_pkg.sv
// Purpose: constants for the upper remappable output selector block
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes:   register indices 7..11, byte address is four times the index
package out_sel_pkg;
    localparam int          SEL_W          = 5;
    localparam int          FIRST_IDX      = 7;
    localparam int          NUM_REGS       = 5;
    localparam int          FIRST_PIN      = 14;
    localparam int          NUM_PINS       = 10;
    localparam int          LARGE_ONLY_PIN = 16;
    localparam int          EVEN_LSB       = 0;
    localparam int          ODD_LSB        = 8;
    localparam logic [15:0] SEL_RESET      = 16'h0000;
    localparam logic [4:0]  FIELD_RESET    = 5'h00;
    localparam logic [7:0]  IDX_PINS_14_15 = 8'h07;
    localparam logic [7:0]  IDX_PINS_16_17 = 8'h08;
    localparam logic [7:0]  IDX_PINS_18_19 = 8'h09;
    localparam logic [7:0]  IDX_PINS_20_21 = 8'h0A;
    localparam logic [7:0]  IDX_PINS_22_23 = 8'h0B;
    localparam int          ADDR_W         = 8;
endpackage : out_sel_pkg

// File: verilog/out_sel_pair.sv
// Purpose: one output select register, two 5-bit pin selectors
// Assumes: write strobe already decoded for this register
// Notes:   present=0 models an absent pair on the small package
`timescale 1ns/1ps
module out_sel_pair
    import out_sel_pkg::*;
#(
    parameter bit PRESENT = 1'b1
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // register access
    input  wire logic              wr_en,
    input  wire logic [15:0]       wdata,
    output logic      [15:0]       rdata,
    // selector values
    output logic      [SEL_W-1:0]  sel_even,
    output logic      [SEL_W-1:0]  sel_odd
);
    typedef struct packed {
        logic [SEL_W-1:0] even_q;
        logic [SEL_W-1:0] odd_q;
    } pair_state_t;

    pair_state_t s_q;
    pair_state_t s_d;

    // only the selector bits are stored; absent pairs never store
    always_comb begin
        s_d = s_q;
        if (wr_en && PRESENT) begin
            s_d.even_q = wdata[EVEN_LSB +: SEL_W];
            s_d.odd_q  = wdata[ODD_LSB +: SEL_W];
        end
    end

    // power-on value of both selectors is zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '{even_q: FIELD_RESET, odd_q: FIELD_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    // unused bits are hard zero, absent pairs read zero
    always_comb begin
        rdata = SEL_RESET;
        if (PRESENT) begin
            rdata[EVEN_LSB +: SEL_W] = s_q.even_q;
            rdata[ODD_LSB +: SEL_W]  = s_q.odd_q;
        end
    end

    assign sel_even = s_q.even_q;
    assign sel_odd  = s_q.odd_q;
endmodule : out_sel_pair

// File: verilog/out_sel_upper.sv
// Purpose: apb register block of output selectors for pins 14..23
// Assumes: one clock, synchronous reset, zero-wait apb slave
// Notes:   selectors drive an external output multiplexer
`timescale 1ns/1ps
module out_sel_upper
    import out_sel_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // function numbers, pin 14 in the low slice
    output logic      [NUM_PINS*SEL_W-1:0] out_func_sel
);
    typedef struct packed {
        logic [31:0]               prdata_q;
        logic                      pready_q;
        logic                      pslverr_q;
        logic [NUM_PINS*SEL_W-1:0] sel_q;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    // pairs from pin 16 upward exist on the large package only
    localparam bit PRES_14_15 =
        (FIRST_PIN < LARGE_ONLY_PIN) || LARGE_PKG;
    localparam bit PRES_16_17 =
        (FIRST_PIN + 2 < LARGE_ONLY_PIN) || LARGE_PKG;
    localparam bit PRES_18_19 =
        (FIRST_PIN + 4 < LARGE_ONLY_PIN) || LARGE_PKG;
    localparam bit PRES_20_21 =
        (FIRST_PIN + 6 < LARGE_ONLY_PIN) || LARGE_PKG;
    localparam bit PRES_22_23 =
        (FIRST_PIN + 8 < LARGE_ONLY_PIN) || LARGE_PKG;

    // bus address split into word index and byte lane
    logic [ADDR_W-3:0]         word_idx;
    logic                      aligned;
    // one hit per output select register
    logic                      hit_14_15;
    logic                      hit_16_17;
    logic                      hit_18_19;
    logic                      hit_20_21;
    logic                      hit_22_23;
    logic [NUM_REGS-1:0]       hit;
    logic                      any_hit;
    // bus phases
    logic                      setup;
    logic                      access;
    logic                      wr_stb;
    // write enables, one per register
    logic [NUM_REGS-1:0]       wr_en;
    // read words of the registers and the selected one
    logic [NUM_REGS-1:0][15:0] rd;
    logic [15:0]               rd_word;
    // selector values out of the register pairs
    logic [SEL_W-1:0]          out_func_sel_pin_14;
    logic [SEL_W-1:0]          out_func_sel_pin_15;
    logic [SEL_W-1:0]          out_func_sel_pin_16;
    logic [SEL_W-1:0]          out_func_sel_pin_17;
    logic [SEL_W-1:0]          out_func_sel_pin_18;
    logic [SEL_W-1:0]          out_func_sel_pin_19;
    logic [SEL_W-1:0]          out_func_sel_pin_20;
    logic [SEL_W-1:0]          out_func_sel_pin_21;
    logic [SEL_W-1:0]          out_func_sel_pin_22;
    logic [SEL_W-1:0]          out_func_sel_pin_23;
    // all selectors, pin 14 in the low slice
    logic [NUM_PINS*SEL_W-1:0] sel_w;

    // byte address is the register index times four
    assign word_idx = paddr[ADDR_W-1:2];
    assign aligned  = (paddr[1:0] == 2'h0);

    // a register answers only to its own aligned word
    assign hit_14_15 = aligned &&
                       (word_idx == IDX_PINS_14_15[ADDR_W-3:0]);
    assign hit_16_17 = aligned &&
                       (word_idx == IDX_PINS_16_17[ADDR_W-3:0]);
    assign hit_18_19 = aligned &&
                       (word_idx == IDX_PINS_18_19[ADDR_W-3:0]);
    assign hit_20_21 = aligned &&
                       (word_idx == IDX_PINS_20_21[ADDR_W-3:0]);
    assign hit_22_23 = aligned &&
                       (word_idx == IDX_PINS_22_23[ADDR_W-3:0]);
    assign hit     = {hit_22_23, hit_20_21, hit_18_19,
                      hit_16_17, hit_14_15};
    assign any_hit = |hit;

    // setup cycle: psel high, penable still low
    assign setup  = psel && !penable;
    // access cycle: pready stands for exactly this one cycle
    assign access = psel && penable && s_q.pready_q;
    // a write lands only at the edge where the master sees pready high,
    // so a request still in its setup cycle cannot move a pin yet
    assign wr_stb = access && pwrite;
    // unmapped words enable nothing, so such writes are dropped
    assign wr_en  = {NUM_REGS{wr_stb}} & hit;

    // pins 14 and 15, kept on both packages
    out_sel_pair #(
        .PRESENT  (PRES_14_15)
    ) u_pair_14_15 (
        .mclk     (mclk),
        .rst      (rst),
        .wr_en    (wr_en[0]),
        .wdata    (pwdata[15:0]),
        .rdata    (rd[0]),
        .sel_even (out_func_sel_pin_14),
        .sel_odd  (out_func_sel_pin_15)
    );

    // pins 16 and 17
    out_sel_pair #(
        .PRESENT  (PRES_16_17)
    ) u_pair_16_17 (
        .mclk     (mclk),
        .rst      (rst),
        .wr_en    (wr_en[1]),
        .wdata    (pwdata[15:0]),
        .rdata    (rd[1]),
        .sel_even (out_func_sel_pin_16),
        .sel_odd  (out_func_sel_pin_17)
    );

    // pins 18 and 19
    out_sel_pair #(
        .PRESENT  (PRES_18_19)
    ) u_pair_18_19 (
        .mclk     (mclk),
        .rst      (rst),
        .wr_en    (wr_en[2]),
        .wdata    (pwdata[15:0]),
        .rdata    (rd[2]),
        .sel_even (out_func_sel_pin_18),
        .sel_odd  (out_func_sel_pin_19)
    );

    // pins 20 and 21
    out_sel_pair #(
        .PRESENT  (PRES_20_21)
    ) u_pair_20_21 (
        .mclk     (mclk),
        .rst      (rst),
        .wr_en    (wr_en[3]),
        .wdata    (pwdata[15:0]),
        .rdata    (rd[3]),
        .sel_even (out_func_sel_pin_20),
        .sel_odd  (out_func_sel_pin_21)
    );

    // pins 22 and 23
    out_sel_pair #(
        .PRESENT  (PRES_22_23)
    ) u_pair_22_23 (
        .mclk     (mclk),
        .rst      (rst),
        .wr_en    (wr_en[4]),
        .wdata    (pwdata[15:0]),
        .rdata    (rd[4]),
        .sel_even (out_func_sel_pin_22),
        .sel_odd  (out_func_sel_pin_23)
    );

    // selector bus for the output multiplexer, pin 14 lowest
    assign sel_w = {
        out_func_sel_pin_23,
        out_func_sel_pin_22,
        out_func_sel_pin_21,
        out_func_sel_pin_20,
        out_func_sel_pin_19,
        out_func_sel_pin_18,
        out_func_sel_pin_17,
        out_func_sel_pin_16,
        out_func_sel_pin_15,
        out_func_sel_pin_14
    };

    // read mux; the word is fetched at the setup edge, so a write that
    // landed in the access cycle just before is already visible
    always_comb begin
        rd_word = 16'h0000;
        if (hit_14_15) begin
            rd_word = rd[0];
        end else if (hit_16_17) begin
            rd_word = rd[1];
        end else if (hit_18_19) begin
            rd_word = rd[2];
        end else if (hit_20_21) begin
            rd_word = rd[3];
        end else if (hit_22_23) begin
            rd_word = rd[4];
        end
    end

    // answer in the access cycle: ready, error and read data for one cycle
    always_comb begin
        s_d           = s_q;
        s_d.sel_q     = sel_w;
        s_d.pready_q  = setup;
        s_d.pslverr_q = setup && !any_hit;
        s_d.prdata_q  = 32'h0000_0000;
        if (setup && !pwrite) begin
            s_d.prdata_q = {16'h0000, rd_word};
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata       = s_q.prdata_q;
    assign pready       = s_q.pready_q;
    assign pslverr      = s_q.pslverr_q;
    assign out_func_sel = s_q.sel_q;
endmodule : out_sel_upper

// File: tb/out_sel_assertions.sv
// Purpose: port checks of the selector block
// Assumes: bound to every out_sel_upper
// Notes:   out_func_sel lags its register by one
`timescale 1ns/1ps
module out_sel_chk
    import out_sel_pkg::*;
#(parameter bit LARGE_PKG = 1'b1) (
    // watched ports
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [49:0]       out_func_sel
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // setup decode, pins 14/15 word is the one both packages keep
    wire logic st = psel && !penable;
    wire logic lo = paddr == 8'h1C;
    wire logic hit = paddr[1:0] == 2'h0 && paddr >= 8'h1C && paddr <= 8'h2C;
    property p_ready; st |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("pready");
    property p_reset; $past(rst) |-> out_func_sel == 50'h0; endproperty
    a_reset: assert property (p_reset) else $error("reset");
    property p_write; st && pwrite && lo |-> ##3 out_func_sel[9:0] ==
        {$past(pwdata[12:8], 3), $past(pwdata[4:0], 3)}; endproperty
    a_write: assert property (p_write) else $error("sel");
    property p_read; st && !pwrite && lo |=> prdata ==
        {19'h0, out_func_sel[9:5], 3'h0, out_func_sel[4:0]}; endproperty
    a_read: assert property (p_read) else $error("read");
    property p_resv; pready && !pwrite |-> prdata[31:13] == 19'h0
        && prdata[7:5] == 3'h0; endproperty
    a_resv: assert property (p_resv) else $error("bits");
    property p_small; pready && !pwrite && !LARGE_PKG && !lo |->
        prdata == 32'h0 && out_func_sel[49:10] == 40'h0; endproperty
    a_small: assert property (p_small) else $error("small");
    property p_unmap; st && !hit |=> pslverr ##1 $stable(out_func_sel);
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmap");
    c_wr: cover property (st && pwrite && hit);
    c_rd: cover property (st && !pwrite && hit);
    c_err: cover property (pready && pslverr);
endmodule : out_sel_chk
bind out_sel_upper out_sel_chk #(.LARGE_PKG(LARGE_PKG)) u_chk (.mclk,
    .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .out_func_sel);

// File: tb/out_sel_upper_tb.sv
// Purpose: random and corner register tests
// Assumes: apb master, pins 14..23
// Notes:   a small-package copy shares the bus
`timescale 1ns/1ps
module out_sel_upper_tb;
    import out_sel_pkg::*;
    logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, prdata_s, rd, rds;
    logic [49:0] sel, sel_s;
    logic [15:0] m [5];
    int          n_mismatch = 0, checks = 0;
    initial forever #5 mclk = ~mclk;
    out_sel_upper dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .out_func_sel(sel));
    out_sel_upper #(.LARGE_PKG(1'b0)) dut_s (.mclk, .rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata(prdata_s),
        .pready(), .pslverr(), .out_func_sel(sel_s));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input logic [49:0] got, input logic [49:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // index 5 lands on an unmapped word
    task automatic xfer(input logic w, input int i, input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 8'h1C + 8'(4 * i);
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1 && ++n < 9);
        rd = prdata;
        rds = prdata_s;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 9) begin
            n_mismatch++;
            conclude();
        end
    endtask : xfer
    // expected selectors, small package keeps only pins 14/15
    function automatic logic [49:0] want(input bit s);
        logic [49:0] v = '0;
        for (int i = 0; i < 5; i++)
            if (!s || i == 0) v[10*i +: 10] = {m[i][12:8], m[i][4:0]};
        return v;
    endfunction : want
    task automatic rw(input int i, input logic [31:0] d);
        logic [49:0] e;
        xfer(1'b1, i, d);
        if (i < 5) m[i] = d[15:0] & 16'h1F1F;
        xfer(1'b0, i, 32'h0);
        e = (i < 5) ? {34'h0, m[i]} : 50'h0;
        chk(rd, e);
        chk(rds, i == 0 ? e : 50'h0);
        chk(err, i == 5);
        chk(sel, want(1'b0));
        chk(sel_s, want(1'b1));
    endtask : rw
    // every register and selector reads zero after a reset
    task automatic zero();
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, i, 32'h0);
            chk(rd, 50'h0);
            chk(rds, 50'h0);
        end
        chk(sel, 50'h0);
        chk(sel_s, 50'h0);
    endtask : zero
    initial begin
        void'($urandom(32'hA358A1DE));
        for (int i = 0; i < 5; i++) m[i] = 16'h0000;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        zero();
        for (int i = 0; i < 6; i++) rw(i, 32'hFFFFFFFF);
        for (int k = 0; k < 40; k++) rw($urandom_range(5), $urandom);
        // reset again mid-run: written selectors must clear
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) m[i] = 16'h0000;
        zero();
        for (int k = 0; k < 10; k++) rw($urandom_range(5), $urandom);
        conclude();
    end
endmodule : out_sel_upper_tb
